// ### rtl/udbc_counters.sv
// Purpose: Up-down counter with completion flag and 8-bit bit-output counter.
// Assumes: Count and reset inputs come from logic on clock_i; no synchroniser.
// Notes:   The present value is signed but stays between 0 and the set value.
//
// Behaviour
// - Up edge adds one, down edge subtracts one from the present value.
// - Counting up, flag sets on step set value to 0, clears on 0 to 1.
// - Counting down, flag sets below 0, clears on step down from set value.
// - Simultaneous up and down edges leave the present value unchanged.
// - Only manual reset or rst_i clears the up-down count; nothing clears it automatically.
// - Reset high forces up-down present value to 0 and flag low.
// - Reset high blocks counting; counting resumes on a fresh edge afterwards.
// - Counts clear at start; an input already high is not counted.
// - Up-down set value ranges 1 to 65535, default 1.
// - Bit counter counts upward only, from 0, one per rising edge.
// - Bit counter tops at 255 and wraps to 0 on the next edge.
// - Bit counter reset is level manual; high clears and blocks counting.
// - Output n carries count bit n-1; output 1 is the LSB.
// - Enabled bit outputs configurable 1 to 8, all 8 by default.
`timescale 1ns/10ps
`default_nettype none
module udbc_counters
  import udbc_pkg::*;
#(
  parameter logic [15:0] SET_VALUE  = UDBC_SV_DEFAULT,
  parameter logic [3:0]  OUT_POINTS = UDBC_PTS_DEFAULT
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic                  ud_up_i,
  input  wire logic                  ud_down_i,
  input  wire logic                  ud_reset_i,
  output logic                       ud_done_o,
  output logic signed [UDBC_PV_W-1:0] ud_pv_o,
  input  wire logic                  bc_in_i,
  input  wire logic                  bc_reset_i,
  output logic [UDBC_BIT_W-1:0]      bc_out_o
);
  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  // Out-of-range settings are clamped so the block never runs unconfigured.
  localparam logic [15:0] SV_EFF  = (SET_VALUE < UDBC_SV_MIN) ? UDBC_SV_MIN : SET_VALUE;
  localparam logic [3:0]  PTS_EFF = (OUT_POINTS < UDBC_PTS_MIN) ? UDBC_PTS_MIN :
                                    (OUT_POINTS > UDBC_PTS_MAX) ? UDBC_PTS_MAX : OUT_POINTS;
  localparam logic signed [UDBC_PV_W-1:0] SV_PV = $signed({1'b0, SV_EFF});

  function automatic logic [UDBC_BIT_W-1:0] udbc_mask(input logic [3:0] pts);
    logic [UDBC_BIT_W-1:0] m;
    m = '0;
    for (int i = 0; i < UDBC_BIT_W; i++) begin
      m[i] = (i < int'(pts));
    end
    return m;
  endfunction : udbc_mask

  localparam logic [UDBC_BIT_W-1:0] OUT_MASK = udbc_mask(PTS_EFF);

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Previous levels reset high so an input already high at start is not counted.
  logic up_prev_r;
  logic dn_prev_r;
  logic bc_prev_r;
  logic up_edge;
  logic dn_edge;
  logic bc_edge;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      up_prev_r <= 1'b1;
      dn_prev_r <= 1'b1;
      bc_prev_r <= 1'b1;
    end else begin
      up_prev_r <= ud_up_i;
      dn_prev_r <= ud_down_i;
      bc_prev_r <= bc_in_i;
    end
  end

  // Previous level keeps tracking during manual reset and is forced high during rst_i,
  // so a level held high across reset is not seen as a new edge afterwards.
  assign up_edge = ud_up_i & ~up_prev_r;
  assign dn_edge = ud_down_i & ~dn_prev_r;
  assign bc_edge = bc_in_i & ~bc_prev_r;

  // ----------------------------------------------------------------
  // Up-down counter
  // ----------------------------------------------------------------
  logic signed [UDBC_PV_W-1:0] pv_r;
  logic signed [UDBC_PV_W-1:0] pv_nxt;
  logic                        done_r;
  logic                        done_nxt;

  always_comb begin
    pv_nxt   = pv_r;
    done_nxt = done_r;
    if (up_edge && !dn_edge) begin
      pv_nxt = pv_r + 17'sd1;
      if (pv_r == SV_PV) begin
        pv_nxt   = '0;
        done_nxt = 1'b1;
      end else if (pv_r == 17'sd0) begin
        done_nxt = 1'b0;
      end
    end else if (dn_edge && !up_edge) begin
      pv_nxt = pv_r - 17'sd1;
      if (pv_r == 17'sd0) begin
        pv_nxt   = SV_PV;
        done_nxt = 1'b1;
      end else if (pv_r == SV_PV) begin
        done_nxt = 1'b0;
      end
    end
  end

  // Both edges together fall through with no change. No auto clear exists.
  always_ff @(posedge clock_i) begin
    if (rst_i || ud_reset_i) begin
      pv_r <= UDBC_PV_RST;
    end else begin
      pv_r <= pv_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || ud_reset_i) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
    end
  end

  assign ud_pv_o   = pv_r;
  assign ud_done_o = done_r;

  // ----------------------------------------------------------------
  // Bit-output counter
  // ----------------------------------------------------------------
  logic [UDBC_BIT_W-1:0] bc_r;

  always_ff @(posedge clock_i) begin
    if (rst_i || bc_reset_i) begin
      bc_r <= UDBC_BIT_RST;
    end else if (bc_edge) begin
      bc_r <= bc_r + 8'h01;
    end
  end

  assign bc_out_o = bc_r & OUT_MASK;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_ud_rst;
    ud_reset_i;
  endsequence

  sequence s_up_only;
    up_edge && !dn_edge && !ud_reset_i;
  endsequence

  sequence s_dn_only;
    dn_edge && !up_edge && !ud_reset_i;
  endsequence

  sequence s_ud_quiet;
    !up_edge && !dn_edge && !ud_reset_i;
  endsequence

  // Manual reset falls while the up input is already high.
  sequence s_ud_rel_high;
    (ud_reset_i && ud_up_i) ##1 (!ud_reset_i && ud_up_i && !ud_down_i);
  endsequence

  sequence s_bc_rst;
    bc_reset_i;
  endsequence

  sequence s_bc_count;
    bc_edge && !bc_reset_i;
  endsequence

  sequence s_bc_rel_high;
    (bc_reset_i && bc_in_i) ##1 (!bc_reset_i && bc_in_i);
  endsequence

  // ----------------------------------------------------------------
  // Checks on the up-down counter
  // ----------------------------------------------------------------
  a_ud_reset_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    s_ud_rst
      |=> (pv_r == UDBC_PV_RST) && !done_r)
    else $error("up-down reset did not clear");

  a_ud_reset_out: assert property (@(posedge clock_i) disable iff (rst_i)
    s_ud_rst
      |=> (ud_pv_o == UDBC_PV_RST) && !ud_done_o)
    else $error("up-down outputs not cleared by reset");

  a_ud_up_step: assert property (@(posedge clock_i) disable iff (rst_i)
    s_up_only ##0 (pv_r != SV_PV)
      |=> (pv_r == $past(pv_r) + 17'sh00001))
    else $error("up edge did not add one");

  a_ud_dn_step: assert property (@(posedge clock_i) disable iff (rst_i)
    s_dn_only ##0 (pv_r != 17'sh00000)
      |=> (pv_r == $past(pv_r) - 17'sh00001))
    else $error("down edge did not subtract one");

  a_ud_both_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    (up_edge && dn_edge && !ud_reset_i)
      |=> $stable(pv_r) && $stable(done_r))
    else $error("simultaneous edges changed count");

  a_ud_quiet_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    s_ud_quiet
      |=> $stable(pv_r) && $stable(done_r))
    else $error("count changed without an edge");

  a_ud_wrap_done: assert property (@(posedge clock_i) disable iff (rst_i)
    s_up_only ##0 (pv_r == SV_PV)
      |=> (pv_r == UDBC_PV_RST) && done_r)
    else $error("wrap to zero did not set flag");

  a_ud_flag_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    s_up_only ##0 (pv_r == 17'sh00000)
      |=> !done_r && (pv_r == 17'sh00001))
    else $error("flag not cleared stepping 0 to 1");

  a_ud_up_keep: assert property (@(posedge clock_i) disable iff (rst_i)
    s_up_only ##0 ((pv_r != SV_PV) && (pv_r != 17'sh00000))
      |=> $stable(done_r))
    else $error("flag moved on a plain up step");

  a_ud_under_done: assert property (@(posedge clock_i) disable iff (rst_i)
    s_dn_only ##0 (pv_r == 17'sh00000)
      |=> done_r && (pv_r == SV_PV))
    else $error("underflow did not set flag");

  a_ud_dn_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    s_dn_only ##0 (pv_r == SV_PV)
      |=> !done_r && (pv_r == SV_PV - 17'sh00001))
    else $error("flag not cleared stepping down from set value");

  a_ud_dn_keep: assert property (@(posedge clock_i) disable iff (rst_i)
    s_dn_only ##0 ((pv_r != SV_PV) && (pv_r != 17'sh00000))
      |=> $stable(done_r))
    else $error("flag moved on a plain down step");

  a_ud_pv_range: assert property (@(posedge clock_i) disable iff (rst_i)
    (pv_r >= 17'sh00000)
      && (pv_r <= SV_PV))
    else $error("present value left its range");

  a_ud_held_high: assert property (@(posedge clock_i) disable iff (rst_i)
    s_ud_rel_high
      |=> (pv_r == UDBC_PV_RST) && !done_r)
    else $error("input held across reset was counted");

  // Start of operation must leave both counters cleared on the first free cycle.
  a_start_clear: assert property (@(posedge clock_i)
    $fell(rst_i)
      |-> (pv_r == UDBC_PV_RST) && !done_r && (bc_r == UDBC_BIT_RST))
    else $error("counters not cleared at start");

  // ----------------------------------------------------------------
  // Checks on the bit-output counter
  // ----------------------------------------------------------------
  a_bc_wrap_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    s_bc_count ##0 (bc_r == UDBC_BIT_MAX)
      |=> (bc_r == UDBC_BIT_RST))
    else $error("bit counter did not wrap");

  a_bc_count_up: assert property (@(posedge clock_i) disable iff (rst_i)
    s_bc_count
      |=> (bc_r == $past(bc_r) + 8'h01))
    else $error("bit counter did not add one");

  a_bc_one_step: assert property (@(posedge clock_i) disable iff (rst_i)
    !bc_reset_i
      |=> (bc_r == $past(bc_r)) || (bc_r == $past(bc_r) + 8'h01))
    else $error("bit counter moved by more than one");

  a_bc_reset_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    bc_reset_i [*2]
      |-> (bc_r == UDBC_BIT_RST))
    else $error("bit counter counted in reset");

  a_bc_reset_out: assert property (@(posedge clock_i) disable iff (rst_i)
    s_bc_rst
      |=> (bc_out_o == UDBC_BIT_RST))
    else $error("bit outputs not cleared by reset");

  a_bc_out_map: assert property (@(posedge clock_i) disable iff (rst_i)
    s_bc_count
      |=> (bc_out_o == (($past(bc_out_o) + 8'h01) & OUT_MASK)))
    else $error("bit output mapping wrong");

  a_edge_needs_low: assert property (@(posedge clock_i) disable iff (rst_i)
    ((!bc_in_i || $past(bc_in_i)) && !bc_reset_i)
      |=> $stable(bc_r))
    else $error("count without a fresh low to high step");

  a_bc_held_high: assert property (@(posedge clock_i) disable iff (rst_i)
    s_bc_rel_high
      |=> (bc_r == UDBC_BIT_RST))
    else $error("bit input held across reset was counted");
endmodule : udbc_counters
`default_nettype wire

// ### shared/udbc_pkg.sv
// Purpose: Shared constants for the up-down and bit-output scan counters.
// Assumes: One controller cycle equals one clock edge of clock_i.
// Notes:   Widths, limits, defaults and reset values only; no timing counts are needed.
`default_nettype none
package udbc_pkg;
  // ----------------------------------------------------------------
  // Widths, limits and defaults
  // ----------------------------------------------------------------
  localparam int unsigned UDBC_PV_W        = 17;
  localparam int unsigned UDBC_SV_W        = 16;
  localparam int unsigned UDBC_BIT_W       = 8;
  localparam logic [15:0] UDBC_SV_DEFAULT  = 16'h0001;
  localparam logic [15:0] UDBC_SV_MIN      = 16'h0001;
  localparam logic [3:0]  UDBC_PTS_DEFAULT = 4'h8;
  localparam logic [3:0]  UDBC_PTS_MIN     = 4'h1;
  localparam logic [3:0]  UDBC_PTS_MAX     = 4'h8;
  // ----------------------------------------------------------------
  // Reset values and bit counter maximum
  // ----------------------------------------------------------------
  localparam logic [16:0] UDBC_PV_RST      = 17'h00000;
  localparam logic [7:0]  UDBC_BIT_RST     = 8'h00;
  localparam logic [7:0]  UDBC_BIT_MAX     = 8'hff;
endpackage : udbc_pkg
`default_nettype wire

// ### test/udbc_src.sv
// Purpose: Model of the program logic that feeds the counter inputs.
// Assumes: One request at a time, taken while busy_o is low.
// Notes:   High is held len_i+1 cycles, then low len_i-1 cycles, so len_i must be 2 or more.
`timescale 1ns/10ps
`default_nettype none
module udbc_src (
  input  wire logic       clock_i,
  input  wire logic       go_i,
  input  wire logic [2:0] req_i,
  input  wire logic [3:0] len_i,
  output logic [2:0]      sig_o,
  output logic            busy_o
);
  logic [4:0] cnt_r;
  initial begin
    sig_o = 3'h0;
    busy_o = 1'b0;
    cnt_r = 5'h00;
  end
  always @(posedge clock_i) begin
    if (!busy_o && go_i) begin
      busy_o <= 1'b1;
      sig_o <= req_i;
      cnt_r <= {len_i, 1'b0};
    end else if (busy_o) begin
      cnt_r <= cnt_r - 5'h01;
      if (cnt_r == {1'b0, len_i}) sig_o <= 3'h0;
      if (cnt_r == 5'h01) busy_o <= 1'b0;
    end
  end
endmodule : udbc_src
`default_nettype wire

// ### test/udbc_counters_test.sv
// Purpose: Self-checking bench for the up-down and bit-output counters.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes:   A set value of 3 lets both wraps occur in a short random run.
`timescale 1ns/10ps
`default_nettype none
module udbc_counters_test import udbc_pkg::*; ();
  localparam logic [15:0] SV = 16'h0003;
  logic                        clock_i, rst_i, ud_res, bc_res, go, busy, ud_done_o, dn;
  logic [2:0]                  req, sig;
  logic [3:0]                  len;
  logic signed [UDBC_PV_W-1:0] ud_pv_o, pv;
  logic [7:0]                  bc_out_o, bc;
  logic [31:0]                 seed;
  logic [25:0]                 notes[$];
  int                          n_fail, n_tests;
  udbc_counters #(.SET_VALUE(SV), .OUT_POINTS(4'h8)) udbc_counters_i (
    .clock_i(clock_i), .rst_i(rst_i), .ud_up_i(sig[0]), .ud_down_i(sig[1]),
    .ud_reset_i(ud_res), .ud_done_o(ud_done_o), .ud_pv_o(ud_pv_o),
    .bc_in_i(sig[2]), .bc_reset_i(bc_res), .bc_out_o(bc_out_o));
  udbc_src udbc_src_i (.clock_i(clock_i), .go_i(go), .req_i(req), .len_i(len),
    .sig_o(sig), .busy_o(busy));
  // ----------------------------------------------------------------
  // Clock, watchdog and checking
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    repeat (50000) @(posedge clock_i);
    n_fail++;
    tally_and_finish();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value outputs expected %h seen %h", exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Outputs are read 2 ns after the edge, once that edge's updates have landed.
  always @(posedge clock_i) begin
    #2;
    if (notes.size() > 0) check({ud_pv_o, ud_done_o, bc_out_o}, notes.pop_front());
  end
  // ----------------------------------------------------------------
  // One pulse on the chosen inputs, with optional manual resets held
  // ----------------------------------------------------------------
  task automatic op(input logic [2:0] r, input logic ur, input logic br, input logic [3:0] l);
    @(posedge clock_i);
    go <= 1'b1;
    req <= r;
    len <= l;
    ud_res <= ur;
    bc_res <= br;
    @(posedge clock_i);
    go <= 1'b0;
    // Resets fall while the inputs are still high, so no count may follow.
    @(posedge clock_i);
    ud_res <= 1'b0;
    bc_res <= 1'b0;
    do @(posedge clock_i); while (busy !== 1'b0);
    @(posedge clock_i);
    if (ur) begin
      pv = '0;
      dn = 1'b0;
    end else if (r[0] && !r[1]) begin
      dn = (pv == SV) ? 1'b1 : ((pv == 0) ? 1'b0 : dn);
      pv = (pv == SV) ? '0 : pv + 1;
    end else if (r[1] && !r[0]) begin
      dn = (pv == 0) ? 1'b1 : ((pv == SV) ? 1'b0 : dn);
      pv = (pv == 0) ? SV : pv - 1;
    end
    bc = br ? 8'h00 : bc + r[2];
    notes.push_back({pv, dn, bc});
  endtask : op
  initial begin
    rst_i = 1'b1;
    ud_res = 1'b0;
    bc_res = 1'b0;
    go = 1'b1;
    req = 3'h5;
    len = 4'h8;
    n_fail = 0;
    n_tests = 0;
    pv = '0;
    dn = 1'b0;
    bc = 8'h00;
    seed = 32'h2bf6b7cc;
    // The inputs are already high when start-up ends, so nothing is counted.
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    go <= 1'b0;
    repeat (20) @(posedge clock_i);
    notes.push_back(26'h0);
    op(3'h5, 1'b1, 1'b1, 4'h2);
    repeat (60) begin
      seed = lfsr(seed);
      op(seed[2:0], seed[7:4] == 4'h0, seed[11:8] == 4'h0, {3'h1, seed[12]});
    end
    repeat (256) op(3'h4, 1'b0, 1'b0, 4'h2);
    repeat (3) @(posedge clock_i);
    tally_and_finish();
  end
endmodule : udbc_counters_test
`default_nettype wire
